//--- bench/host_model.sv
// Purpose: Host processor model driving the parallel port pins.
// Assumes: Pins change just after a rising clock edge.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/1ns
module host_model
    import host_port_pkg::*;
(
    // Clock and port side
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic oe_in,
    input wire logic [15:0] data_in,
    // Pins
    output host_pins_t pins_out,
    output logic drv_out
);
    int hangs = 0;
    initial pins_out = PINS_IDLE;
    initial drv_out = 1'b0;

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_in !== 1'b1 && n < 200)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 200)
            hangs++;
    endtask

    task automatic release_bus();
        @(posedge clk_in);
        pins_out.data <= ~pins_out.data;
        drv_out <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    task automatic config_pins(input logic m, input logic sh,
        input logic fl, input logic rs);
        pins_out.mode <= m;
        pins_out.shared_bus_select <= sh;
        pins_out.float_n <= fl;
        pins_out.reset_n <= rs;
        repeat (5) @(posedge clk_in);
    endtask

    task automatic latch_addr(input logic [15:0] a);
        wait_ready();
        pins_out.data <= a;
        drv_out <= 1'b1;
        pins_out.port_select_n <= 1'b0;
        pins_out.addr_strobe_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        pins_out.addr_strobe_n <= 1'b1;
        pins_out.port_select_n <= 1'b1;
        release_bus();
    endtask

    task automatic xfer(input logic rd, input logic [1:0] sel,
        input logic [17:0] a, input logic [15:0] wd,
        output logic [15:0] rdat);
        int n;
        wait_ready();
        pins_out.access_sel <= sel;
        pins_out.addr <= a;
        pins_out.direction <= rd ? DIR_READ : ~DIR_READ;
        pins_out.data <= rd ? ~pins_out.data : wd;
        drv_out <= !rd;
        pins_out.port_select_n <= 1'b0;
        @(posedge clk_in);
        pins_out.data_strobe_1_n <= 1'b0;
        n = 0;
        rdat = 16'h0;
        do
        begin
            @(posedge clk_in);
            n++;
            if (rd && oe_in === 1'b1)
                rdat = data_in;
        end while (n < 4 || (rd && oe_in !== 1'b1 && n < 200));
        if (n >= 200)
            hangs++;
        pins_out.data_strobe_1_n <= 1'b1;
        pins_out.port_select_n <= 1'b1;
        release_bus();
    endtask
endmodule // host_model

//--- bench/host_port_block_chk.sv
// Purpose: Port-level assertions for the parallel host port.
// Assumes: Host pins pass a two-flop synchroniser.
// Notes: Repeats of 3 or 4 cover the pin latency.
`timescale 1ns/1ns
module host_port_block_chk
    import host_port_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    // Watched ports
    input wire host_pins_t HOST_PINS_IN,
    input wire logic HOST_DATA_BUS_OE_OUT,
    input wire logic HOST_PORT_READY_OUT,
    input wire logic HOST_PORT_READY_OE_OUT,
    input wire logic HOST_IRQ_SUB_A_N_OUT,
    input wire logic HOST_IRQ_SUB_A_OE_OUT,
    input wire logic HOST_IRQ_SUB_B_N_OUT,
    input wire logic HOST_IRQ_SUB_B_OE_OUT,
    input wire logic SUB_A_IRQ_SET_IN,
    input wire logic SUBSYS_RESET_OUT,
    input wire ram_req_t RAM_REQ_OUT,
    input wire ram_rsp_t RAM_RSP_IN,
    input wire wb_req_t WB_REQ_IN,
    input wire wb_rsp_t WB_RSP_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    logic any_oe;
    assign any_oe = HOST_DATA_BUS_OE_OUT | HOST_PORT_READY_OE_OUT |
        HOST_IRQ_SUB_A_OE_OUT | HOST_IRQ_SUB_B_OE_OUT;

    wb_ack_a: assert property (WB_REQ_IN.cyc && WB_REQ_IN.stb &&
        !WB_RSP_OUT.ack |=> WB_RSP_OUT.ack) else $error("ack missing");
    ack_pulse_a: assert property (WB_RSP_OUT.ack |=> !WB_RSP_OUT.ack)
        else $error("ack longer than one cycle");
    float_off_a: assert property (
        (!HOST_PINS_IN.float_n)[*3] |-> !any_oe)
        else $error("output driven while floated");
    shared_off_a: assert property (
        HOST_PINS_IN.shared_bus_select[*3] |-> !any_oe)
        else $error("output driven while pins not owned");
    ready_busy_a: assert property (
        RAM_REQ_OUT.req |-> !HOST_PORT_READY_OUT)
        else $error("ready high during RAM access");
    oe_ready_a: assert property (
        HOST_DATA_BUS_OE_OUT |-> HOST_PORT_READY_OUT && !RAM_REQ_OUT.req)
        else $error("data driven while busy");
    ram_hold_a: assert property (
        RAM_REQ_OUT.req && !RAM_RSP_IN.ack |=>
        RAM_REQ_OUT.req && $stable(RAM_REQ_OUT.addr))
        else $error("RAM request dropped early");
    irq_set_a: assert property (
        (!HOST_PINS_IN.mode && HOST_PINS_IN.reset_n)[*3] ##0
        SUB_A_IRQ_SET_IN |-> ##[1:2] !HOST_IRQ_SUB_A_N_OUT)
        else $error("subsystem interrupt not raised");
    nonmux_irq_a: assert property (
        HOST_PINS_IN.mode[*4] |->
        HOST_IRQ_SUB_A_N_OUT && HOST_IRQ_SUB_B_N_OUT)
        else $error("interrupt pin low in non-multiplexed mode");
    subsys_rst_a: assert property (
        (!HOST_PINS_IN.reset_n)[*4] |-> SUBSYS_RESET_OUT)
        else $error("subsystem reset not asserted");

    cover property (RAM_REQ_OUT.we && RAM_RSP_IN.ack);
    cover property (HOST_DATA_BUS_OE_OUT);
    cover property (!HOST_IRQ_SUB_A_N_OUT);
endmodule // host_port_block_chk

bind host_port_block host_port_block_chk chk_i (.CLOCK_IN, .RESET_IN,
    .HOST_PINS_IN, .HOST_DATA_BUS_OE_OUT, .HOST_PORT_READY_OUT,
    .HOST_PORT_READY_OE_OUT, .HOST_IRQ_SUB_A_N_OUT, .HOST_IRQ_SUB_A_OE_OUT,
    .HOST_IRQ_SUB_B_N_OUT, .HOST_IRQ_SUB_B_OE_OUT, .SUB_A_IRQ_SET_IN,
    .SUBSYS_RESET_OUT, .RAM_REQ_OUT, .RAM_RSP_IN, .WB_REQ_IN, .WB_RSP_OUT);

//--- bench/test_host_port_block.sv
// Purpose: Self-checking bench for the parallel host port.
// Assumes: RAM answers one cycle after a request.
// Notes: Expected RAM contents are kept in exp_mem.
`timescale 1ns/1ns
module test_host_port_block;
    import host_port_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic set_a = 1'b0;
    logic set_b = 1'b0;
    host_pins_t hp;
    host_pins_t pins;
    logic drv, oe, keep, rdy, rdy_oe, a_n, a_oe, b_n, b_oe, srst, irq;
    logic [15:0] bus_out;
    logic [15:0] hold;
    ram_req_t ram_q;
    ram_rsp_t ram_s = '0;
    wb_req_t wbq = '0;
    wb_rsp_t wbs;
    logic [15:0] mem [int];
    int exp_mem [int];
    int err_count = 0;
    int compares = 0;
    int ram_writes = 0;
    logic [17:0] last_wa = '0;

    always #20 clk = ~clk;

    // Resolve the shared data lines
    always_comb
    begin
        pins = hp;
        if (oe)
            pins.data = bus_out;
        else if (keep && !drv)
            pins.data = hold;
    end

    always @(posedge clk)
    begin
        ram_s.ack <= ram_q.req && !ram_s.ack;
        if (ram_q.req && !ram_s.ack && ram_q.we)
        begin
            mem[ram_q.addr] = ram_q.wdata;
            last_wa <= ram_q.addr;
            ram_writes++;
        end
        ram_s.rdata <= (ram_q.req && !ram_s.ack && mem.exists(ram_q.addr))
            ? mem[ram_q.addr] : ~ram_s.rdata;
    end

    host_port_block uut (.CLOCK_IN(clk), .RESET_IN(rst), .HOST_PINS_IN(pins),
        .HOST_DATA_BUS_OUT(bus_out), .HOST_DATA_BUS_OE_OUT(oe),
        .HOST_DATA_HOLD_OUT(hold), .HOST_DATA_KEEP_OUT(keep),
        .HOST_PORT_READY_OUT(rdy), .HOST_PORT_READY_OE_OUT(rdy_oe),
        .HOST_IRQ_SUB_A_N_OUT(a_n), .HOST_IRQ_SUB_A_OE_OUT(a_oe),
        .HOST_IRQ_SUB_B_N_OUT(b_n), .HOST_IRQ_SUB_B_OE_OUT(b_oe),
        .SUB_A_IRQ_SET_IN(set_a), .SUB_B_IRQ_SET_IN(set_b),
        .SUBSYS_RESET_OUT(srst), .RAM_REQ_OUT(ram_q), .RAM_RSP_IN(ram_s),
        .WB_REQ_IN(wbq), .WB_RSP_OUT(wbs), .IRQ_OUT(irq));
    host_model host (.clk_in(clk), .ready_in(rdy), .oe_in(oe),
        .data_in(bus_out), .pins_out(hp), .drv_out(drv));

    task automatic wrap_up();
        err_count += host.hangs;
        $display("Counts: %0d compares, %0d errors", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic fin(input string s);
        if (host.hangs > 0)
            wrap_up();
        $display("Test %s done", s);
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wbq <= '{1'b1, 1'b1, w, a, d, 4'hf};
        do
        begin
            @(posedge clk);
            n++;
        end while (wbs.ack !== 1'b1 && n < 50);
        q = wbs.dat;
        wbq <= '0;
        if (n >= 50)
        begin
            err_count++;
            wrap_up();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic pulse();
        set_a <= 1'b1;
        set_b <= 1'b1;
        @(posedge clk);
        set_a <= 1'b0;
        set_b <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        logic [31:0] q;
        logic [15:0] r;
        logic [15:0] d;
        int a;
        a = $urandom(53);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(keep, 1'b0);
        chk(rdy, 1'b1);
        wb(1'b0, REG_BANK_SWITCH, 32'h0, q);
        chk(q, {31'h0, KEEPER_RESET});
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0);
        fin("reset");
        host.config_pins(1'b0, 1'b0, 1'b1, 1'b1);
        a = $urandom_range(16'hfff0);
        host.latch_addr(a[15:0]);
        wb(1'b0, REG_PORT_STATUS, 32'h0, q);
        chk(q[17:0], a[17:0]);
        chk(q[29:28], 2'h2);
        for (int i = 0; i < 5; i++)
        begin
            d = $urandom;
            host.xfer(1'b0, i < 3 ? SEL_DATA_INC : SEL_DATA_FIX, 18'h0, d, r);
            exp_mem[a + (i < 3 ? i : 3)] = d;
            chk(last_wa, a + (i < 3 ? i : 3));
        end
        host.xfer(1'b0, SEL_ADDR, 18'h0, a[15:0], r);
        for (int i = 0; i < 4; i++)
        begin
            host.xfer(1'b1, SEL_DATA_INC, 18'h0, 16'h0, r);
            chk(r, exp_mem[a + i]);
        end
        host.xfer(1'b1, SEL_ADDR, 18'h0, 16'h0, r);
        chk(r, a + 4);
        wb(1'b0, REG_IRQ_STATUS, 32'h0, q);
        chk(q[2:1], 2'h3);
        wb(1'b1, REG_IRQ_MASK, 32'h2, q);
        chk(irq, 1'b1);
        wb(1'b1, REG_IRQ_STATUS, 32'h2, q);
        chk(irq, 1'b0);
        fin("multiplexed");
        pulse();
        chk({a_n, b_n}, 2'h0);
        host.xfer(1'b0, SEL_CONTROL, 18'h0, 16'h000c, r);
        chk({a_n, b_n}, 2'h2);
        wb(1'b0, REG_IRQ_STATUS, 32'h0, q);
        chk(q[0], 1'b1);
        fin("interrupt");
        host.config_pins(1'b1, 1'b0, 1'b1, 1'b1);
        pulse();
        chk({a_n, b_n}, 2'h3);
        a = $urandom_range(18'h3ffff);
        d = $urandom;
        exp_mem[a] = d;
        host.xfer(1'b0, SEL_CONTROL, a[17:0], d, r);
        chk(last_wa, a[17:0]);
        host.xfer(1'b1, SEL_CONTROL, a[17:0], 16'h0, r);
        chk(r, exp_mem[a]);
        wb(1'b1, REG_BANK_SWITCH, 32'h1, q);
        chk(keep, 1'b1);
        chk(hold, d);
        fin("non-multiplexed");
        host.config_pins(1'b0, 1'b0, 1'b0, 1'b1);
        chk({oe, rdy_oe, a_oe, b_oe}, 4'h0);
        host.config_pins(1'b0, 1'b1, 1'b1, 1'b1);
        a = ram_writes;
        host.xfer(1'b0, SEL_DATA_INC, 18'h0, 16'h5a5a, r);
        chk(ram_writes, a);
        chk(rdy_oe, 1'b0);
        host.config_pins(1'b0, 1'b0, 1'b1, 1'b0);
        chk(srst, 1'b1);
        chk(keep, 1'b0);
        host.config_pins(1'b0, 1'b0, 1'b1, 1'b1);
        chk({srst, a_n, b_n}, 3'h3);
        fin("float and reset");
        wrap_up();
    end
endmodule // test_host_port_block

//--- src/host_pin_sync.sv
// Purpose: Two-stage synchroniser for every host pin input.
// Assumes: Pins are asynchronous to CLOCK_IN.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
module host_pin_sync
    import host_port_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    // Pins
    input wire host_pins_t PINS_IN,
    output host_pins_t PINS_OUT
);

    typedef struct packed {
        host_pins_t stage1;
        host_pins_t stage2;
    } sync_state_t;

    sync_state_t q;
    sync_state_t next_q;

    always_comb
    begin
        next_q.stage1 = PINS_IN;
        next_q.stage2 = q.stage1;
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
            q <= '{stage1: PINS_IDLE, stage2: PINS_IDLE};
        else
            q <= next_q;
    end

    assign PINS_OUT = q.stage2;

endmodule // host_pin_sync

//--- src/host_port_block.sv
// Purpose: Device side of a 16-bit parallel host port into on-chip RAM.
// Assumes: Host pins are asynchronous; RAM answers with a one-cycle ack.
// Notes: Pin resolution (tri-state, keeper) is left to the pad/bench.
//
// Overview of operation
// - Shared pins serve port only when select low
// - Keepers hold last driven level on data lines; code tracks data phases only, not the address strobe phase
// - Keepers reset disabled, software enable bit
// - Float input low tri-states data, ready, interrupts
// - Multiplexed mode: control inputs pick port register
// - Multiplexed mode: address strobe latches address
// - Ready high only when next transfer acceptable
// - Subsystem interrupts drive own pin low, multiplexed
// - Host writing one clears pending interrupt
// - Data bus carries RAM data both ways
// - Mode low multiplexed, high non-multiplexed
// - No interrupts in non-multiplexed mode
// - Port reset resets port and both subsystems
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ns
module host_port_block
    import host_port_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    // Host pins
    input wire host_pins_t HOST_PINS_IN,
    output logic [15:0] HOST_DATA_BUS_OUT,
    output logic HOST_DATA_BUS_OE_OUT,
    output logic [15:0] HOST_DATA_HOLD_OUT,
    output logic HOST_DATA_KEEP_OUT,
    output logic HOST_PORT_READY_OUT,
    output logic HOST_PORT_READY_OE_OUT,
    output logic HOST_IRQ_SUB_A_N_OUT,
    output logic HOST_IRQ_SUB_A_OE_OUT,
    output logic HOST_IRQ_SUB_B_N_OUT,
    output logic HOST_IRQ_SUB_B_OE_OUT,
    // Subsystems
    input wire logic SUB_A_IRQ_SET_IN,
    input wire logic SUB_B_IRQ_SET_IN,
    output logic SUBSYS_RESET_OUT,
    // On-chip RAM
    output ram_req_t RAM_REQ_OUT,
    input wire ram_rsp_t RAM_RSP_IN,
    // Register bus
    input wire wb_req_t WB_REQ_IN,
    output wb_rsp_t WB_RSP_OUT,
    output logic IRQ_OUT
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        xfer_state_t xfer;
        logic strobe_d;
        logic addr_strobe_n_d;
        logic is_read;
        logic [1:0] target;
        logic inc;
        logic [17:0] addr;
        logic [15:0] hold_data;
        logic [15:0] out_data;
        logic [15:0] last_level;
        logic irq_a;
        logic irq_b;
        logic keeper;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic wb_ack;
        logic [31:0] wb_dat;
        ram_req_t ram;
    } state_t;

    localparam state_t STATE_RESET = '{
        xfer: ST_IDLE,
        strobe_d: 1'b0,
        addr_strobe_n_d: 1'b1,
        is_read: 1'b0,
        target: SEL_CONTROL,
        inc: 1'b0,
        addr: 18'h00000,
        hold_data: 16'h0000,
        out_data: 16'h0000,
        last_level: 16'h0000,
        irq_a: 1'b0,
        irq_b: 1'b0,
        keeper: KEEPER_RESET,
        irq_status: EV_RESET,
        irq_mask: EV_RESET,
        wb_ack: 1'b0,
        wb_dat: 32'h00000000,
        ram: '{req: 1'b0, we: 1'b0, addr: 18'h00000, wdata: 16'h0000}
    };

    host_pins_t pins;
    state_t q;
    state_t next_q;

    logic active;
    logic mux_mode;
    logic strobe;
    logic strobe_rise;
    logic addr_strobe_fall;
    logic drive;
    logic [15:0] ctrl_value;
    logic [2:0] events;
    logic [2:0] w1c;
    logic clr_a;
    logic clr_b;
    logic wb_hit;
    logic [31:0] wb_read;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    host_pin_sync u_sync (
        .CLOCK_IN(CLOCK_IN),
        .RESET_IN(RESET_IN),
        .PINS_IN(HOST_PINS_IN),
        .PINS_OUT(pins)
    );

    // ----------------------------------------------------------------
    // Pin decode
    // ----------------------------------------------------------------
    // shared pin ownership
    assign active = ~pins.shared_bus_select;
    assign mux_mode = ~pins.mode;
    assign strobe = active & ~pins.port_select_n &
        (~pins.data_strobe_1_n | ~pins.data_strobe_2_n);
    assign strobe_rise = strobe & ~q.strobe_d;
    assign addr_strobe_fall = active & mux_mode &
        q.addr_strobe_n_d & ~pins.addr_strobe_n;
    assign drive = (q.xfer == ST_DRIVE) & active;

    always_comb
    begin
        ctrl_value = 16'h0000;
        ctrl_value[CTRL_MODE_BIT] = pins.mode;
        ctrl_value[CTRL_IRQ_A_BIT] = q.irq_a;
        ctrl_value[CTRL_IRQ_B_BIT] = q.irq_b;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        events = 3'h0;
        clr_a = 1'b0;
        clr_b = 1'b0;
        next_q.strobe_d = strobe;
        next_q.addr_strobe_n_d = pins.addr_strobe_n;

        if (addr_strobe_fall)
            next_q.addr = {2'h0, pins.data};

        case (q.xfer)
            ST_IDLE:
            begin
                if (strobe_rise)
                begin
                    next_q.is_read = (pins.direction == DIR_READ);
                    next_q.target = mux_mode ? pins.access_sel
                        : SEL_DATA_FIX;
                    next_q.inc = mux_mode &
                        (pins.access_sel == SEL_DATA_INC);
                    if (!mux_mode)
                        next_q.addr = pins.addr;
                    if (pins.direction == DIR_READ)
                    begin
                        if (mux_mode && pins.access_sel == SEL_CONTROL)
                        begin
                            next_q.out_data = ctrl_value;
                            next_q.xfer = ST_DRIVE;
                        end
                        else if (mux_mode && pins.access_sel == SEL_ADDR)
                        begin
                            next_q.out_data = q.addr[15:0];
                            next_q.xfer = ST_DRIVE;
                        end
                        else
                        begin
                            next_q.ram.req = 1'b1;
                            next_q.ram.we = 1'b0;
                            next_q.ram.addr = mux_mode ? q.addr : pins.addr;
                            next_q.xfer = ST_RAM;
                        end
                    end
                    else
                    begin
                        next_q.hold_data = pins.data;
                        next_q.xfer = ST_WAIT_END;
                    end
                end
            end
            ST_WAIT_END:
            begin
                if (strobe)
                    next_q.hold_data = pins.data;
                else
                begin
                    next_q.xfer = ST_IDLE;
                    if (q.target == SEL_CONTROL)
                    begin
                        clr_a = q.hold_data[CTRL_IRQ_A_BIT];
                        clr_b = q.hold_data[CTRL_IRQ_B_BIT];
                        events[EV_HOST_IRQ] = mux_mode &
                            q.hold_data[CTRL_DSP_IRQ_BIT];
                    end
                    else if (q.target == SEL_ADDR)
                        next_q.addr = {2'h0, q.hold_data};
                    else
                    begin
                        next_q.ram.req = 1'b1;
                        next_q.ram.we = 1'b1;
                        next_q.ram.addr = q.addr;
                        next_q.ram.wdata = q.hold_data;
                        next_q.xfer = ST_RAM;
                    end
                end
            end
            ST_RAM:
            begin
                if (RAM_RSP_IN.ack)
                begin
                    next_q.ram.req = 1'b0;
                    if (q.is_read)
                    begin
                        next_q.out_data = RAM_RSP_IN.rdata;
                        next_q.xfer = ST_DRIVE;
                    end
                    else
                    begin
                        events[EV_WRITE] = 1'b1;
                        if (q.inc)
                            next_q.addr = q.addr + 18'h00001;
                        next_q.xfer = ST_IDLE;
                    end
                end
            end
            ST_DRIVE:
            begin
                if (!strobe)
                begin
                    events[EV_READ] = (q.target != SEL_CONTROL) &
                        (q.target != SEL_ADDR);
                    if (q.inc)
                        next_q.addr = q.addr + 18'h00001;
                    next_q.xfer = ST_IDLE;
                end
            end
            default:
            begin
                next_q.xfer = ST_IDLE;
            end
        endcase

        if (drive)
            next_q.last_level = q.out_data;
        else if (q.xfer == ST_WAIT_END && strobe)
            next_q.last_level = pins.data;

        next_q.irq_a = mux_mode & ((q.irq_a & ~clr_a) | SUB_A_IRQ_SET_IN);
        next_q.irq_b = mux_mode & ((q.irq_b & ~clr_b) | SUB_B_IRQ_SET_IN);

        // Wishbone slave, one wait state
        next_q.wb_ack = wb_hit;
        next_q.wb_dat = wb_hit ? wb_read : 32'h00000000;
        w1c = 3'h0;
        if (wb_hit && WB_REQ_IN.we && WB_REQ_IN.sel[0])
        begin
            case (WB_REQ_IN.adr)
                REG_BANK_SWITCH: next_q.keeper = WB_REQ_IN.dat[KEEPER_BIT];
                REG_IRQ_STATUS: w1c = WB_REQ_IN.dat[EV_W-1:0];
                REG_IRQ_MASK: next_q.irq_mask = WB_REQ_IN.dat[EV_W-1:0];
                default: next_q.irq_mask = q.irq_mask;
            endcase
        end
        next_q.irq_status = (q.irq_status & ~w1c) | events;

        if (!pins.reset_n)
            next_q = STATE_RESET;
    end

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    assign wb_hit = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~q.wb_ack;

    always_comb
    begin
        wb_read = 32'h00000000;
        case (WB_REQ_IN.adr)
            REG_BANK_SWITCH: wb_read[KEEPER_BIT] = q.keeper;
            REG_IRQ_STATUS: wb_read[EV_W-1:0] = q.irq_status;
            REG_IRQ_MASK: wb_read[EV_W-1:0] = q.irq_mask;
            REG_PORT_STATUS: wb_read = {q.irq_b, q.irq_a, active,
                pins.mode, 10'h000, q.addr};
            default: wb_read = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
            q <= STATE_RESET;
        else
            q <= next_q;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // float gates every driver
    assign HOST_DATA_BUS_OE_OUT = drive & pins.float_n;
    assign HOST_DATA_BUS_OUT = q.out_data;
    assign HOST_DATA_HOLD_OUT = q.last_level;
    assign HOST_DATA_KEEP_OUT = q.keeper;
    assign HOST_PORT_READY_OUT = (q.xfer != ST_RAM);
    assign HOST_PORT_READY_OE_OUT = active & pins.float_n;
    assign HOST_IRQ_SUB_A_N_OUT = ~q.irq_a;
    assign HOST_IRQ_SUB_B_N_OUT = ~q.irq_b;
    assign HOST_IRQ_SUB_A_OE_OUT = active & pins.float_n;
    assign HOST_IRQ_SUB_B_OE_OUT = active & pins.float_n;
    assign SUBSYS_RESET_OUT = RESET_IN | ~pins.reset_n;
    assign RAM_REQ_OUT = q.ram;
    assign WB_RSP_OUT = '{ack: q.wb_ack, dat: q.wb_dat};
    assign IRQ_OUT = |(q.irq_status & q.irq_mask);

endmodule // host_port_block

//--- src/host_port_pkg.sv
// Purpose: Shared types and constants of the parallel host port.
// Assumes: One 25 MHz clock; register bus is classic Wishbone.
// Notes: Pin bundle, bus carriers, register map and access codes.
package host_port_pkg;

    // ----------------------------------------------------------------
    // Widths and clock
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int WB_ADDR_W = 8;
    localparam int CLOCK_HZ = 25000000;

    // ----------------------------------------------------------------
    // Host access select codes, multiplexed mode
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;
    localparam logic [1:0] SEL_DATA_FIX = 2'h3;

    // Direction level that means a host read
    localparam logic DIR_READ = 1'b1;

    // ----------------------------------------------------------------
    // Port control register fields as the host sees them
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_DSP_IRQ_BIT = 2;
    localparam int CTRL_IRQ_A_BIT = 3;
    localparam int CTRL_IRQ_B_BIT = 4;

    // ----------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_BANK_SWITCH = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_PORT_STATUS = 8'h0c;
    localparam int KEEPER_BIT = 0;
    localparam logic KEEPER_RESET = 1'b0;

    // Event bits of status and mask
    localparam int EV_W = 3;
    localparam int EV_HOST_IRQ = 0;
    localparam int EV_WRITE = 1;
    localparam int EV_READ = 2;
    localparam logic [2:0] EV_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] data;
        logic [1:0] access_sel;
        logic addr_strobe_n;
        logic port_select_n;
        logic data_strobe_1_n;
        logic data_strobe_2_n;
        logic direction;
        logic mode;
        logic shared_bus_select;
        logic float_n;
        logic reset_n;
    } host_pins_t;

    localparam host_pins_t PINS_IDLE = '{
        addr: 18'h00000,
        data: 16'h0000,
        access_sel: 2'h0,
        addr_strobe_n: 1'b1,
        port_select_n: 1'b1,
        data_strobe_1_n: 1'b1,
        data_strobe_2_n: 1'b1,
        direction: 1'b1,
        mode: 1'b0,
        shared_bus_select: 1'b1,
        float_n: 1'b1,
        reset_n: 1'b1
    };

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [17:0] addr;
        logic [15:0] wdata;
    } ram_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } ram_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_END,
        ST_RAM,
        ST_DRIVE
    } xfer_state_t;

endpackage
